// >>> shared/cap_pkg.sv
// Package for the camera ascii command parser: constants and carrier types.
`default_nettype none
package cap_pkg;
  // Clock, serial and timing constants.
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned CLK_NS      = 1_000_000_000 / CLK_HZ;
  localparam int unsigned BAUD        = 9600;
  localparam int unsigned BIT_CYC     = CLK_HZ / BAUD;
  localparam int unsigned TIMEOUT_S   = 15;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam int unsigned EXT_MIN_NS  = 1_000_000;
  localparam int unsigned EXT_MIN_CYC = EXT_MIN_NS / CLK_NS;
  localparam int unsigned EXPO_BASE_NS  = 156_000;
  localparam int unsigned EXPO_STEP_NS  = 10_240;
  localparam int unsigned EXPO_BASE_CYC = (EXPO_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EXPO_STEP_CYC = (EXPO_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STOP_IDX = 4'hb - 4'h2;
  localparam logic [3:0] TX_SLOTS = 4'hb;
  localparam logic [2:0] NAME_MAX = 3'h5;
  localparam logic [1:0] ND_MAX   = 2'h3;
  // Characters.
  localparam logic [7:0] CH_CR = 8'h0d, CH_LF = 8'h0a, CH_QM = 8'h3f, CH_EQ = 8'h3d;
  localparam logic [7:0] CH_0 = 8'h30, CH_9 = 8'h39, CH_A = 8'h61, CH_Z = 8'h7a;
  localparam logic [7:0] CH_UO = 8'h4f, CH_UK = 8'h4b, CH_UN = 8'h4e, CH_UG = 8'h47;
  localparam logic [7:0] CH_UE = 8'h45, CH_UC = 8'h43, CH_UT = 8'h54;
  // Command names, packed right aligned.
  localparam logic [39:0] NM_CTRL = 40'h006374726c, NM_DIPSW = 40'h6469707377;
  localparam logic [39:0] NM_ID   = 40'h0000006964, NM_BIT   = 40'h0000626974;
  localparam logic [39:0] NM_SYNC = 40'h0073796e63, NM_EXPC  = 40'h0065787063;
  localparam logic [39:0] NM_EXPT = 40'h0065787074;
  // Argument limits and decimal helpers.
  localparam logic [9:0] LIM_BIN = 10'h001, LIM_BYTE = 10'h0ff, LIM_EXPC = 10'h002;
  localparam logic [9:0] DEC_BASE = 10'h00a, ARG_W8 = 10'h008, ARG_W10 = 10'h00a;
  localparam logic [7:0] DEC_HUND = 8'h64, DEC_TEN = 8'h0a;
  localparam logic [7:0] VAL_W8 = 8'h08, VAL_W10 = 8'h0a;
  localparam logic [3:0] GAIN_MIN = 4'h1;
  // Register map.
  localparam logic [7:0] A_CTRL = 8'h00, A_STAT = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_CTRL, CMD_DIPSW, CMD_ID, CMD_BIT, CMD_SYNC, CMD_EXPC, CMD_EXPT
  } cap_cmd_type;
  typedef enum logic [2:0] {RK_VAL, RK_OK, RK_NG, RK_NE, RK_NC} cap_kind_type;
  typedef struct packed {
    logic       ctrl;
    logic [7:0] unit_identifier;
    logic       width10;
    logic       sync;
    logic [1:0] expc;
    logic [7:0] expt;
  } cap_cfg_type;
  localparam cap_cfg_type CFG_RST = '0;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } cap_axi_req_type;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cap_axi_rsp_type;
endpackage
`default_nettype wire

// >>> hw/cap_parser.sv
// Serial ascii command interpreter with trigger, exposure and register logic.
// Function
// - Serial frames are 1 start, 8 data, no parity, 1 stop bit at 9600 baud.
// - Command names are lower case only; upper case makes the line invalid.
// - Only single-byte characters; multi-byte or blank characters are invalid.
// - CR, LF or CR+LF end a line; every reply ends with CR alone.
// - Malformed or unknown commands get the syntax error reply.
// - Out-of-range arguments get the range error reply; setting unchanged.
// - Serial-only settings written under switch control get NC and are rejected.
// - No terminator within 15 s of line start: drop the line, reply timeout.
// - A query with or without trailing question mark returns the value.
// - Setting source select: 0 switch bank, 1 serial commands.
// - The switch query returns the eight switches as decimal 0 to 255.
// - Unit identifier 0 to 255, default 0, readable and writable.
// - Output width 8 (default) or 10, written only under serial control.
// - Line trigger source: 0 internal, 1 external.
// - External trigger with period under 1 ms falls back to internal.
// - Exposure mode 0, 1 or 2, written only under serial control.
// - Gain step defaults to times one, raised to times eight by the selector.
// - Exposure length 0 to 255, written only under serial control.
// - Fixed exposure lasts 156 us plus 10.24 us per unit from trigger edge.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`default_nettype none
module cap_parser #(
  parameter int unsigned TIMEOUT_CYCLES   = cap_pkg::TIMEOUT_CYC,
  parameter int unsigned EXT_MIN_CYCLES   = cap_pkg::EXT_MIN_CYC,
  parameter int unsigned EXPO_BASE_CYCLES = cap_pkg::EXPO_BASE_CYC,
  parameter int unsigned EXPO_STEP_CYCLES = cap_pkg::EXPO_STEP_CYC,
  parameter int unsigned BIT_CYCLES       = cap_pkg::BIT_CYC
) (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     srst,
  // Serial link.
  input  wire logic                     rxd,
  output var  logic                     txd_q,
  // Switch bank, gain selector and external trigger.
  input  wire logic [7:0]               dip_sw,
  input  wire logic [2:0]               gain_switch,
  input  wire logic                     ext_sync,
  // Camera controls.
  output var  cap_pkg::cap_cfg_type     cfg_q,
  output var  logic                     width10_eff_q,
  output var  logic                     ext_trig_sel_q,
  output var  logic                     expose_q,
  output var  logic [3:0]               gain_step_q,
  // Register bus.
  input  wire cap_pkg::cap_axi_req_type axi_req,
  output var  cap_pkg::cap_axi_rsp_type axi_rsp_q
);
  import cap_pkg::*;

  logic [11:0] rx_cnt_q, tx_cnt_q;
  logic [3:0]  rx_bit_q, tx_left_q;
  logic [7:0]  rx_sh_q;
  logic [9:0]  tx_sh_q;
  logic        rx_busy_q, rx_stb_q, rx_en_q;
  logic [39:0] name_q;
  logic [2:0]  name_len_q;
  logic [1:0]  nd_q;
  logic [9:0]  val_q;
  logic [31:0] to_cnt_q;
  logic        bad_q, has_eq_q, has_qm_q, big_q, line_act_q, exec_q;
  logic [7:0]  rep_q [4];
  logic [7:0]  rep_d [4];
  logic [2:0]  rep_len_q, rep_idx_q, rep_len_d;
  logic        take, is_term, is_lower, is_digit, rep_idle, exec_go, to_go, tx_load;
  logic        locked, in_rng, wr_hit_q, wr_bit_q;
  cap_cmd_type  cmd;
  cap_kind_type kind;
  logic [7:0]  qval;

  // Receiver: samples each bit in its middle; a bad stop bit drops the byte.
  always_ff @(posedge clk) begin
    rx_stb_q <= 1'b0;
    if (srst) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
    end else if (!rx_busy_q) begin
      if (!rxd) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= 12'(BIT_CYCLES / 2 - 1);
        rx_bit_q  <= '0;
      end
    end else if (rx_cnt_q != '0) begin
      rx_cnt_q <= rx_cnt_q - 12'h001;
    end else begin
      rx_cnt_q <= 12'(BIT_CYCLES - 1);
      rx_bit_q <= rx_bit_q + 4'h1;
      if (rx_bit_q == '0 && rxd) begin
        rx_busy_q <= 1'b0;  // Glitch, not a start bit.
      end else if (rx_bit_q == STOP_IDX) begin
        rx_busy_q <= 1'b0;
        rx_stb_q  <= rxd;
      end else if (rx_bit_q != '0) begin
        rx_sh_q <= {rxd, rx_sh_q[7:1]};
      end
    end
  end

  // Transmitter: one extra idle slot keeps the stop bit a full bit long.
  always_ff @(posedge clk) begin
    if (srst) begin
      txd_q     <= 1'b1;
      tx_left_q <= '0;
      tx_cnt_q  <= '0;
      tx_sh_q   <= '1;
    end else if (tx_load) begin
      tx_sh_q   <= {1'b1, rep_q[rep_idx_q[1:0]], 1'b0};
      tx_left_q <= TX_SLOTS;
      tx_cnt_q  <= '0;
    end else if (tx_left_q != '0) begin
      if (tx_cnt_q == '0) begin
        txd_q     <= tx_sh_q[0];
        tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
        tx_cnt_q  <= 12'(BIT_CYCLES - 1);
        tx_left_q <= tx_left_q - 4'h1;
      end else begin
        tx_cnt_q <= tx_cnt_q - 12'h001;
      end
    end
  end

  // Character classes and handshake terms.
  assign take     = rx_stb_q && rx_en_q && !exec_q;
  assign is_term  = rx_sh_q == CH_CR || rx_sh_q == CH_LF;
  assign is_lower = rx_sh_q >= CH_A && rx_sh_q <= CH_Z;
  assign is_digit = rx_sh_q >= CH_0 && rx_sh_q <= CH_9;
  assign rep_idle = rep_idx_q == rep_len_q;
  assign tx_load  = !rep_idle && tx_left_q == '0;
  assign exec_go  = exec_q && rep_idle;
  assign to_go    = line_act_q && !exec_q && rep_idle && to_cnt_q >= TIMEOUT_CYCLES - 1;

  // Line state; every executed or timed out line starts the next one empty.
  always_ff @(posedge clk) begin
    if (srst || exec_go || to_go) begin
      name_q     <= '0;
      name_len_q <= '0;
      nd_q       <= '0;
      val_q      <= '0;
      to_cnt_q   <= '0;
      bad_q      <= 1'b0;
      has_eq_q   <= 1'b0;
      has_qm_q   <= 1'b0;
      big_q      <= 1'b0;
      line_act_q <= 1'b0;
      exec_q     <= 1'b0;
    end else begin
      if (line_act_q) begin
        to_cnt_q <= to_cnt_q + 32'h1;
      end
      if (take) begin
        if (is_term) begin
          exec_q <= line_act_q;
        end else begin
          line_act_q <= 1'b1;
          if (has_qm_q) begin
            bad_q <= 1'b1;
          end else if (is_lower && !has_eq_q) begin
            if (name_len_q == NAME_MAX) begin
              bad_q <= 1'b1;
            end else begin
              name_q     <= {name_q[31:0], rx_sh_q};
              name_len_q <= name_len_q + 3'h1;
            end
          end else if (rx_sh_q == CH_QM && !has_eq_q) begin
            has_qm_q <= 1'b1;
          end else if (rx_sh_q == CH_EQ && !has_eq_q && name_len_q != '0) begin
            has_eq_q <= 1'b1;
          end else if (is_digit && has_eq_q) begin
            if (nd_q == ND_MAX) begin
              big_q <= 1'b1;  // More than three digits is always out of range.
            end else begin
              val_q <= 10'(val_q * DEC_BASE + 10'(rx_sh_q[3:0]));
              nd_q  <= nd_q + 2'h1;
            end
          end else begin
            bad_q <= 1'b1;
          end
        end
      end
    end
  end

  // Decode the finished line into a command, its value and the reply kind.
  always_comb begin
    unique case (name_q)
      NM_CTRL:  cmd = CMD_CTRL;
      NM_DIPSW: cmd = CMD_DIPSW;
      NM_ID:    cmd = CMD_ID;
      NM_BIT:   cmd = CMD_BIT;
      NM_SYNC:  cmd = CMD_SYNC;
      NM_EXPC:  cmd = CMD_EXPC;
      NM_EXPT:  cmd = CMD_EXPT;
      default:  cmd = CMD_NONE;
    endcase
    qval   = '0;
    locked = 1'b0;
    in_rng = 1'b0;
    unique case (cmd)
      CMD_NONE: ;
      CMD_CTRL: begin
        qval   = 8'(cfg_q.ctrl);
        in_rng = val_q <= LIM_BIN;
      end
      CMD_DIPSW: qval = dip_sw;
      CMD_ID: begin
        qval   = cfg_q.unit_identifier;
        in_rng = val_q <= LIM_BYTE;
      end
      CMD_BIT: begin
        qval   = cfg_q.width10 ? VAL_W10 : VAL_W8;
        locked = 1'b1;
        in_rng = val_q == ARG_W8 || val_q == ARG_W10;
      end
      CMD_SYNC: begin
        qval   = 8'(cfg_q.sync);
        in_rng = val_q <= LIM_BIN;
      end
      CMD_EXPC: begin
        qval   = 8'(cfg_q.expc);
        locked = 1'b1;
        in_rng = val_q <= LIM_EXPC;
      end
      CMD_EXPT: begin
        qval   = cfg_q.expt;
        locked = 1'b1;
        in_rng = val_q <= LIM_BYTE;
      end
    endcase
    // Lock is checked before range, so a locked write under switch control never reports NE.
    if (bad_q || cmd == CMD_NONE) begin
      kind = RK_NG;
    end else if (!has_eq_q) begin
      kind = RK_VAL;
    end else if (nd_q == '0 || cmd == CMD_DIPSW) begin
      kind = RK_NG;
    end else if (locked && !cfg_q.ctrl) begin
      kind = RK_NC;
    end else if (big_q || !in_rng) begin
      kind = RK_NE;
    end else begin
      kind = RK_OK;
    end
  end

  // Reply text: value digits or two letters, always closed by a lone CR.
  always_comb begin
    rep_d[0]  = CH_UT;
    rep_d[1]  = CH_UO;
    rep_d[2]  = CH_CR;
    rep_d[3]  = CH_CR;
    rep_len_d = 3'h3;
    if (!to_go) begin
      unique case (kind)
        RK_OK: rep_d[1] = CH_UK;
        RK_NG: rep_d[1] = CH_UG;
        RK_NE: rep_d[1] = CH_UE;
        RK_NC: rep_d[1] = CH_UC;
        RK_VAL: ;
      endcase
      rep_d[0] = (kind == RK_OK) ? CH_UO : CH_UN;
      if (kind == RK_VAL) begin
        if (qval >= DEC_HUND) begin
          rep_d[0]  = CH_0 | qval / DEC_HUND;
          rep_d[1]  = CH_0 | (qval / DEC_TEN) % DEC_TEN;
          rep_d[2]  = CH_0 | qval % DEC_TEN;
          rep_len_d = 3'h4;
        end else if (qval >= DEC_TEN) begin
          rep_d[0]  = CH_0 | qval / DEC_TEN;
          rep_d[1]  = CH_0 | qval % DEC_TEN;
        end else begin
          rep_d[0]  = CH_0 | qval;
          rep_d[1]  = CH_CR;
          rep_len_d = 3'h2;
        end
      end
    end
  end

  // Reply buffer and its send pointer.
  always_ff @(posedge clk) begin
    if (srst) begin
      rep_len_q <= '0;
      rep_idx_q <= '0;
      rep_q     <= '{default: '0};
    end else if (exec_go || to_go) begin
      rep_q     <= rep_d;
      rep_len_q <= rep_len_d;
      rep_idx_q <= '0;
    end else if (tx_load) begin
      rep_idx_q <= rep_idx_q + 3'h1;
    end
  end

  // Settings are only touched by an accepted write.
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= CFG_RST;
    end else if (exec_go && kind == RK_OK) begin
      unique case (cmd)
        CMD_NONE, CMD_DIPSW: ;
        CMD_CTRL: cfg_q.ctrl            <= val_q[0];
        CMD_ID:   cfg_q.unit_identifier <= val_q[7:0];
        CMD_BIT:  cfg_q.width10         <= val_q == ARG_W10;
        CMD_SYNC: cfg_q.sync            <= val_q[0];
        CMD_EXPC: cfg_q.expc            <= val_q[1:0];
        CMD_EXPT: cfg_q.expt            <= val_q[7:0];
      endcase
    end
  end

  // Trigger period check, fallback, exposure timing and gain step.
  logic        ext_d_q, ext_ok_q, ext_rise;
  logic [15:0] per_cnt_q;
  logic [16:0] expo_cnt_q;
  assign ext_rise = ext_sync && !ext_d_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_d_q        <= 1'b0;
      ext_ok_q       <= 1'b0;
      per_cnt_q      <= '0;
      ext_trig_sel_q <= 1'b0;
      width10_eff_q  <= 1'b0;
      gain_step_q    <= GAIN_MIN;
    end else begin
      ext_d_q        <= ext_sync;
      gain_step_q    <= 4'(gain_switch) + GAIN_MIN;
      width10_eff_q  <= cfg_q.ctrl ? cfg_q.width10 : dip_sw[0];
      ext_trig_sel_q <= cfg_q.sync && ext_ok_q;
      if (ext_rise) begin
        ext_ok_q  <= per_cnt_q >= 16'(EXT_MIN_CYCLES - 1);
        per_cnt_q <= '0;
      end else if (per_cnt_q != '1) begin
        per_cnt_q <= per_cnt_q + 16'h1;
      end
    end
  end

  // Exposure modes apply only under serial control; otherwise whole line.
  always_ff @(posedge clk) begin
    if (srst) begin
      expo_cnt_q <= '0;
      expose_q   <= 1'b0;
    end else if (cfg_q.ctrl && cfg_q.expc == 2'h1) begin
      if (ext_rise) begin
        expo_cnt_q <= 17'(EXPO_BASE_CYCLES) + 17'(EXPO_STEP_CYCLES) * 17'(cfg_q.expt);
      end else if (expo_cnt_q != '0) begin
        expo_cnt_q <= expo_cnt_q - 17'h1;
      end
      expose_q <= ext_rise || expo_cnt_q > 17'h1;
    end else begin
      expo_cnt_q <= '0;
      expose_q   <= (cfg_q.ctrl && cfg_q.expc == 2'h2) ? ext_sync : 1'b1;
    end
  end

  // Register bus slave: address and data taken in either order.
  always_ff @(posedge clk) begin
    if (srst) begin
      axi_rsp_q         <= '0;
      axi_rsp_q.awready <= 1'b1;
      axi_rsp_q.wready  <= 1'b1;
      axi_rsp_q.arready <= 1'b1;
      rx_en_q           <= 1'b1;
      wr_hit_q          <= 1'b0;
      wr_bit_q          <= 1'b0;
    end else begin
      if (axi_req.awvalid && axi_rsp_q.awready) begin
        axi_rsp_q.awready <= 1'b0;
        axi_rsp_q.bresp   <= axi_req.awaddr == A_CTRL ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_req.wvalid && axi_rsp_q.wready) begin
        axi_rsp_q.wready <= 1'b0;
        wr_hit_q         <= axi_req.wstrb[0];
        wr_bit_q         <= axi_req.wdata[0];
      end
      // The data bit waits until the address is known, so a stray write changes nothing.
      if (!axi_rsp_q.awready && !axi_rsp_q.wready && !axi_rsp_q.bvalid) begin
        axi_rsp_q.bvalid <= 1'b1;
        if (axi_rsp_q.bresp == RESP_OKAY && wr_hit_q) begin
          rx_en_q <= wr_bit_q;
        end
      end
      if (axi_rsp_q.bvalid && axi_req.bready) begin
        axi_rsp_q.bvalid  <= 1'b0;
        axi_rsp_q.awready <= 1'b1;
        axi_rsp_q.wready  <= 1'b1;
      end
      if (axi_req.arvalid && axi_rsp_q.arready) begin
        axi_rsp_q.arready <= 1'b0;
        axi_rsp_q.rvalid  <= 1'b1;
        axi_rsp_q.rresp   <= RESP_OKAY;
        if (axi_req.araddr == A_CTRL) begin
          axi_rsp_q.rdata <= 32'(rx_en_q);
        end else if (axi_req.araddr == A_STAT) begin
          axi_rsp_q.rdata <= {9'h0, ext_ok_q, line_act_q, cfg_q};
        end else begin
          axi_rsp_q.rdata <= '0;
          axi_rsp_q.rresp <= RESP_SLVERR;
        end
      end
      if (axi_rsp_q.rvalid && axi_req.rready) begin
        axi_rsp_q.rvalid  <= 1'b0;
        axi_rsp_q.arready <= 1'b1;
      end
    end
  end

  // Checks on the interpreter and the camera controls.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_reply_ends_cr: assert property (tx_load && rep_idx_q == rep_len_q - 3'h1 |=>
    tx_sh_q[8:1] == CH_CR) else $error("Reply does not end in CR.");
  a_upper_is_bad: assert property (take && !is_term && rx_sh_q >= CH_UC && rx_sh_q <= CH_UT
    |=> bad_q || !line_act_q) else $error("Upper case char accepted.");
  a_blank_is_bad: assert property (take && rx_sh_q == 8'h20 |=> bad_q || !line_act_q)
    else $error("Blank char accepted.");
  a_timeout_reply: assert property (to_go |=> !line_act_q && rep_q[0] == CH_UT
    && rep_len_q == 3'h3) else $error("Timeout did not reply.");
  a_range_keep: assert property (exec_go && kind == RK_NE |=> $stable(cfg_q)
    && rep_q[1] == CH_UE) else $error("Range error changed settings.");
  a_lock_keep: assert property (exec_go && kind == RK_NC |=> $stable(cfg_q)
    && !cfg_q.ctrl) else $error("Locked write changed settings.");
  a_ok_reply: assert property (exec_go && kind == RK_OK |=> rep_q[0] == CH_UO
    && rep_q[1] == CH_UK ##1 !rep_idle) else $error("Accepted write gave no OK.");
  a_fast_fallback: assert property (ext_rise && per_cnt_q < 16'(EXT_MIN_CYCLES - 1)
    |=> !ext_ok_q ##1 !ext_trig_sel_q) else $error("Fast trigger not rejected.");
  a_expo_load: assert property (ext_rise && cfg_q.ctrl && cfg_q.expc == 2'h1 |=>
    expose_q && expo_cnt_q == 17'(EXPO_BASE_CYCLES) + 17'(EXPO_STEP_CYCLES)
    * 17'($past(cfg_q.expt))) else $error("Exposure length wrong.");
  c_ok_write: cover property (exec_go && kind == RK_OK);
  c_timeout: cover property (to_go);
  c_fallback: cover property (ext_trig_sel_q ##1 !ext_trig_sel_q);
endmodule
`default_nettype wire

// >>> sim/cap_host.sv
// Host terminal model: sends command bytes and collects the reply bytes.
`default_nettype none
module cap_host
  import cap_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYC
) (
  // Clock.
  input  wire logic clk,
  // Serial link, seen from the host.
  output var  logic rxd,
  input  wire logic txd_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  initial rxd = 1'b1;
  // One frame: start low, eight data bits lsb first, stop high.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= fr[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask
  // Receiver samples mid bit; a bad stop bit is queued as ff so it shows.
  always begin
    logic [7:0] b;
    @(negedge txd_q);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      b[i] = txd_q;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    rx_q.push_back((txd_q === 1'b1) ? b : 8'hff);
  end
endmodule
`default_nettype wire

// >>> sim/camera_ascii_command_parser_test.sv
// Self-checking bench for the command parser over serial and register bus.
`default_nettype none
module camera_ascii_command_parser_test;
  import cap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SIM_BIT = 16;
  localparam int unsigned SIM_TO  = 2000;
  localparam int unsigned SIM_EXT = 200;
  localparam int unsigned SIM_EB  = 10;
  localparam int unsigned SIM_ES  = 2;
  logic            clk;
  logic            srst;
  logic            rxd;
  logic            txd_q;
  logic [7:0]      dip_sw;
  logic [2:0]      gain_switch;
  logic            ext_sync;
  cap_cfg_type     cfg_q;
  logic            width10_eff_q;
  logic [3:0]      gain_step_q;
  logic            ext_trig_sel_q;
  logic            expose_q;
  int              n;
  cap_axi_req_type axi_req;
  cap_axi_rsp_type axi_rsp_q;
  int              n_errors;
  int              check_count;
  int              cycles;
  logic [31:0]     rd;
  logic [1:0]      rr;
  cap_cfg_type     e;
  // Device under test with bit time and timeouts short enough to simulate.
  cap_parser #(.TIMEOUT_CYCLES(SIM_TO), .EXT_MIN_CYCLES(SIM_EXT), .EXPO_BASE_CYCLES(SIM_EB),
    .EXPO_STEP_CYCLES(SIM_ES), .BIT_CYCLES(SIM_BIT)) dut (.clk(clk), .srst(srst), .rxd(rxd),
    .txd_q(txd_q), .dip_sw(dip_sw), .gain_switch(gain_switch), .ext_sync(ext_sync),
    .cfg_q(cfg_q), .width10_eff_q(width10_eff_q), .ext_trig_sel_q(ext_trig_sel_q),
    .expose_q(expose_q), .gain_step_q(gain_step_q), .axi_req(axi_req), .axi_rsp_q(axi_rsp_q));
  cap_host #(.BIT_CYCLES(SIM_BIT)) u_host (.clk(clk), .rxd(rxd), .txd_q(txd_q));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask
  // Send a line, then compare each reply byte as it arrives.
  task automatic cmd(input string s, input string exp);
    logic [7:0] b;
    for (int i = 0; i < s.len(); i++) u_host.send_byte(s[i]);
    for (int i = 0; i < exp.len(); i++) begin
      for (int k = 0; k < 2 * SIM_TO && u_host.rx_q.size() == 0; k++) @(posedge clk);
      b = (u_host.rx_q.size() > 0) ? u_host.rx_q.pop_front() : 8'h00;
      check({"reply to ", s}, {24'h0, b}, {24'h0, exp[i]});
    end
    repeat (SIM_BIT * 2) @(posedge clk);
    check("extra reply bytes", u_host.rx_q.size(), 0);
  endtask
  // One trigger pulse of five cycles; counts exposure cycles over the gap that follows.
  task automatic trig(input int gap, output int cnt);
    cnt = 0;
    @(posedge clk);
    ext_sync <= 1'b1;
    for (int i = 0; i < gap; i++) begin
      @(posedge clk);
      if (i == 4) begin
        ext_sync <= 1'b0;
      end
      if (expose_q === 1'b1) begin
        cnt++;
      end
    end
  endtask
  // Bus write: address and data offered together, each dropped when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!aw && axi_rsp_q.awready === 1'b1) begin
        aw = 1'b1;
        axi_req.awvalid <= 1'b0;
      end
      if (!w && axi_rsp_q.wready === 1'b1) begin
        w = 1'b1;
        axi_req.wvalid <= 1'b0;
      end
    end while (axi_rsp_q.bvalid !== 1'b1);
    r = axi_rsp_q.bresp;
    axi_req.bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'b0;
    @(posedge clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (!ar && axi_rsp_q.arready === 1'b1) begin
        ar = 1'b1;
        axi_req.arvalid <= 1'b0;
      end
    end while (axi_rsp_q.rvalid !== 1'b1);
    d = axi_rsp_q.rdata;
    r = axi_rsp_q.rresp;
    axi_req.rready <= 1'b0;
  endtask
  // Cycle ceiling: the shortened serial traffic needs some twenty-two thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    srst = 1'b1;
    dip_sw = 8'ha4;
    gain_switch = 3'h7;
    ext_sync = 1'b0;
    axi_req = '0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    check("cfg after reset", cfg_q, CFG_RST);
    check("width from switch", width10_eff_q, 1'b0);
    check("gain step", gain_step_q, 4'h8);
    axi_rd(A_CTRL, rd, rr);
    check("ctrl reg", rd, 32'h1);
    axi_rd(8'h08, rd, rr);
    check("unmapped read", {rr, rd[29:0]}, {RESP_SLVERR, 30'h0});
    axi_wr(8'h0c, 32'h0, rr);
    check("unmapped write", rr, RESP_SLVERR);
    axi_rd(A_CTRL, rd, rr);
    check("ctrl after stray write", rd, 32'h1);
    $display("test reset and bus done");
    cmd("id=7\r", "OK\r");
    cmd("id?\n", "7\r");
    cmd("id\r\n", "7\r");
    cmd("Id\r", "NG\r");
    cmd("x y\r", "NG\r");
    $display("test queries done");
    cmd("bit=10\r", "NC\r");
    cmd("ctrl=1\r", "OK\r");
    cmd("bit=9\r", "NE\r");
    cmd("bit=10\r", "OK\r");
    check("width selected", width10_eff_q, 1'b1);
    cmd("dipsw\r", "164\r");
    $display("test settings done");
    cmd("e", "TO\r");
    cmd("ctrl\r", "1\r");
    e = CFG_RST;
    e.ctrl = 1'b1;
    e.unit_identifier = 8'h07;
    e.width10 = 1'b1;
    axi_rd(A_STAT, rd, rr);
    check("status reg", rd, {11'h0, e});
    $display("test timeout and status done");
    cmd("sync=1\r", "OK\r");
    cmd("expc=1\r", "OK\r");
    cmd("expt=3\r", "OK\r");
    trig(300, n);
    check("exposure cycles", n, SIM_EB + SIM_ES * 3);
    check("external trigger used", ext_trig_sel_q, 1'b1);
    trig(50, n);
    trig(50, n);
    check("short period exposure", n, SIM_EB + SIM_ES * 3);
    check("fast trigger fallback", ext_trig_sel_q, 1'b0);
    $display("test trigger and exposure done");
    final_report();
  end
endmodule
`default_nettype wire
